// ---- obt_defines.svh ----
`ifndef OBT_DEFINES_SVH
`define OBT_DEFINES_SVH
// register byte offsets
`define OBT_CTRL_OFF 12'h000
`define OBT_CNT_OFF 12'h004
`define OBT_STAT_OFF 12'h008
`define OBT_MASK_OFF 12'h00C
`define OBT_CLKDIV_OFF 12'h010
`define OBT_CPU_OFF 12'h014
// control register fields
`define OBT_CTRL_DATA 0
`define OBT_CTRL_MODE_LO 1
`define OBT_CTRL_MODE_HI 2
`define OBT_CTRL_CNTHI_LO 6
`define OBT_CTRL_CNTHI_HI 7
// status / mask fields
`define OBT_FLAG_EMPTY 0
`define OBT_FLAG_CAPT 1
`define OBT_FLAG_DONE 2
// cpu-side control fields
`define OBT_CPU_GIE 0
`define OBT_CPU_MULTI 1
`define OBT_CPU_RETI 2
// vector addresses
`define OBT_VEC_DONE 10'h002
`define OBT_VEC_EMPTY 10'h004
// interrupt sequencing cycles
`define OBT_ENTRY_CYC 3'd4
`define OBT_JUMP_CYC 3'd2
`define OBT_RETI_CYC 3'd4
// reset values
`define OBT_CTRL_RST 8'h00
`define OBT_CNT_RST 8'h00
`define OBT_DIV_RST 8'h00
`endif

// ---- obt_pkg.sv ----
package obt_pkg;
  typedef enum logic [1:0] {
    OBT_MODE_OFF = 2'h0,
    OBT_MODE_TX = 2'h1,
    OBT_MODE_RX = 2'h2,
    OBT_MODE_GEN = 2'h3
  } obt_mode_t;
  typedef enum logic [4:0] {
    OBT_IS_RUN = 5'b00001,
    OBT_IS_ENTRY = 5'b00010,
    OBT_IS_JUMP = 5'b00100,
    OBT_IS_HANDLER = 5'b01000,
    OBT_IS_RETURN = 5'b10000
  } obt_isq_t;
  typedef struct packed {
    logic valid;
    logic [9:0] vector;
  } obt_irq_t;
endpackage

// ---- obt_bit_timer.sv ----
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "obt_defines.svh"

// How it works
// - each bit slot lasts one tick period times one plus the 10-bit count built from control bits 7:6 over the count register.
// - in transmit mode the key output follows the buffered data bit slot by slot.
// - the carrier reaches the antenna driver only while the keyed bit is one.
// - taking the bit out of the buffer sets flag 0 and, if enabled, requests vector 0x04.
// - the counter hitting zero with the buffer empty sets flag 2 and, if enabled, requests vector 0x02.
// - flags are set whether or not their interrupts are enabled so software may poll them.
// - in receive mode the counter counts up from zero and each input edge copies its low eight bits into the count register.
// - a captured rising edge sets the data bit and a falling edge clears it.
// - generic timer mode never keys the transmitter and flags when the count interval elapses.
// - a programmable divider makes the tick from the master clock.
// - no interrupt is served unless the global enable bit is set.
// - interrupt entry takes four cycles pushing the pc, then the vector jump takes two more.
// - a multi-cycle instruction in progress finishes before interrupt entry begins.
// - return takes four cycles popping the pc, then one main instruction runs before another interrupt.
// - the status register is not saved by hardware on interrupt entry.
module obt_bit_timer
  import obt_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic carrier_in, // synthesized carrier
  input wire logic capture_input_pin, // receiver output
  output logic key_out, // transmitter key
  output logic rf_out, // gated carrier to antenna driver
  output logic irq, // level interrupt
  output logic [9:0] irq_vector, // vector being served
  output logic irq_ack // one-cycle vector fetch strobe
);

  // the count is built from two fixed register fields, so no other width fits
  if (CNT_W != 10) begin : g_width_check
    $error("obt_bit_timer: count width must be 10");
  end

  // ==========================================================
  // registers
  logic [7:0] bit_timer_control_reg;
  logic [7:0] bit_count_reg;
  logic [2:0] status;
  logic [2:0] mask;
  logic [7:0] power_clock_control;
  logic [7:0] processor_status_reg;
  logic [2:0] div_cnt;
  logic tick;
  logic [CNT_W-1:0] counter;
  logic buf_full;
  logic key_bit;
  logic cap_prev;
  logic running;
  obt_isq_t isq;
  logic [2:0] isq_cnt;
  logic after_reti;

  obt_mode_t mode;
  logic [CNT_W-1:0] countval;
  logic wr_en;
  logic rd_en;
  logic ctrl_wr;
  logic cnt_wr;
  logic stat_wr;
  logic slot_end;
  logic take_bit;
  logic tx_done;
  logic gen_done;
  logic cap_edge;
  obt_irq_t pend;
  obt_mode_t mode_next;
  logic mode_chg;
  logic mask_wr;
  logic div_wr;
  logic cpu_wr;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  function automatic logic [9:0] count_of(input logic [7:0] ctrl, input logic [7:0] cnt);
    count_of = {ctrl[`OBT_CTRL_CNTHI_HI:`OBT_CTRL_CNTHI_LO], cnt};
  endfunction

  // set wins over a clear in the same cycle so no event is lost
  function automatic logic sticky(input logic set, input logic cur, input logic clr);
    sticky = set || (cur && !clr);
  endfunction

  assign mode = obt_mode_t'(bit_timer_control_reg[`OBT_CTRL_MODE_HI:`OBT_CTRL_MODE_LO]);
  assign countval = count_of(bit_timer_control_reg, bit_count_reg);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign ctrl_wr = wr_en && addr_hit(paddr, `OBT_CTRL_OFF);
  assign cnt_wr = wr_en && addr_hit(paddr, `OBT_CNT_OFF);
  assign stat_wr = wr_en && addr_hit(paddr, `OBT_STAT_OFF);
  assign slot_end = tick && (counter == '0);
  assign take_bit = (mode == OBT_MODE_TX) && slot_end && buf_full;
  // running stops an idle zero count from flagging done again
  assign tx_done = (mode == OBT_MODE_TX) && running && slot_end && !buf_full;
  assign gen_done = (mode == OBT_MODE_GEN) && slot_end;
  assign cap_edge = (mode == OBT_MODE_RX) && (capture_input_pin != cap_prev);
  assign mode_next = obt_mode_t'(pwdata[`OBT_CTRL_MODE_HI:`OBT_CTRL_MODE_LO]);
  assign mode_chg = ctrl_wr && (mode_next != mode);
  assign mask_wr = wr_en && addr_hit(paddr, `OBT_MASK_OFF);
  assign div_wr = wr_en && addr_hit(paddr, `OBT_CLKDIV_OFF);
  assign cpu_wr = wr_en && addr_hit(paddr, `OBT_CPU_OFF);

  // ==========================================================
  // apb slave: one wait-free access, unmapped reads zero with error
  // read data is latched in setup so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_en || (psel && !penable && pwrite);
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `OBT_CTRL_OFF: prdata <= {24'h000000, bit_timer_control_reg};
          `OBT_CNT_OFF: prdata <= {24'h000000, bit_count_reg};
          `OBT_STAT_OFF: prdata <= {29'h00000000, status};
          `OBT_MASK_OFF: prdata <= {29'h00000000, mask};
          `OBT_CLKDIV_OFF: prdata <= {24'h000000, power_clock_control};
          `OBT_CPU_OFF: prdata <= {24'h000000, processor_status_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // tick divider
  // a setting of n gives one tick every n+1 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end else if (div_cnt >= power_clock_control[2:0]) begin
      div_cnt <= 3'h0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // control, data bit and buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_timer_control_reg <= `OBT_CTRL_RST;
      buf_full <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        bit_timer_control_reg <= pwdata[7:0];
        buf_full <= (mode_next == OBT_MODE_TX);
      end else if (take_bit) begin
        buf_full <= 1'b0;
      end
      if (cap_edge) begin
        bit_timer_control_reg[`OBT_CTRL_DATA] <= capture_input_pin;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_count_reg <= `OBT_CNT_RST;
    end else if (cap_edge) begin
      bit_count_reg <= counter[7:0];
    end else if (cnt_wr) begin
      bit_count_reg <= pwdata[7:0];
    end
  end

  // resets to the receiver's idle low so leaving reset shows no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= capture_input_pin;
    end
  end

  // ==========================================================
  // counter and keying
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= '0;
      key_bit <= 1'b0;
      running <= 1'b0;
    end else begin
      if (mode_chg) begin
        // generic mode starts on a full interval so its first flag is not early
        if (mode_next == OBT_MODE_GEN) begin
          counter <= count_of(pwdata[7:0], bit_count_reg);
        end else begin
          counter <= '0;
        end
        running <= 1'b0;
        key_bit <= 1'b0;
      end else begin
        unique case (mode)
          OBT_MODE_TX: begin
            if (take_bit) begin
              counter <= countval;
              key_bit <= bit_timer_control_reg[`OBT_CTRL_DATA];
              running <= 1'b1;
            end else if (tx_done) begin
              key_bit <= 1'b0;
              running <= 1'b0;
            end else if (tick && counter != '0) begin
              counter <= counter - 1'b1;
            end
          end
          // holds at full scale so a long gap never wraps to a short width
          OBT_MODE_RX: begin
            if (cap_edge) begin
              counter <= '0;
            end else if (tick && counter != '1) begin
              counter <= counter + 1'b1;
            end
          end
          OBT_MODE_GEN: begin
            key_bit <= 1'b0;
            if (slot_end) begin
              counter <= countval;
            end else if (tick) begin
              counter <= counter - 1'b1;
            end
          end
          default: begin
            counter <= '0;
            key_bit <= 1'b0;
            running <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_out <= 1'b0;
      rf_out <= 1'b0;
    end else begin
      key_out <= key_bit && (mode == OBT_MODE_TX);
      rf_out <= carrier_in && key_bit && (mode == OBT_MODE_TX);
    end
  end

  // ==========================================================
  // flags: set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else begin
      status[`OBT_FLAG_EMPTY] <= sticky(take_bit, status[`OBT_FLAG_EMPTY],
        stat_wr && pwdata[`OBT_FLAG_EMPTY]);
      status[`OBT_FLAG_CAPT] <= sticky(cap_edge, status[`OBT_FLAG_CAPT],
        stat_wr && pwdata[`OBT_FLAG_CAPT]);
      status[`OBT_FLAG_DONE] <= sticky(tx_done || gen_done, status[`OBT_FLAG_DONE],
        stat_wr && pwdata[`OBT_FLAG_DONE]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= 3'h0;
    end else if (mask_wr) begin
      mask <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_clock_control <= `OBT_DIV_RST;
    end else if (div_wr) begin
      power_clock_control <= pwdata[7:0];
    end
  end

  // ==========================================================
  // interrupt sequencer; lower vector wins
  always_comb begin
    pend.valid = 1'b0;
    pend.vector = 10'h000;
    if (status[`OBT_FLAG_DONE] && mask[`OBT_FLAG_DONE]) begin
      pend.valid = 1'b1;
      pend.vector = `OBT_VEC_DONE;
    end else if ((status[`OBT_FLAG_EMPTY] && mask[`OBT_FLAG_EMPTY]) ||
                 (status[`OBT_FLAG_CAPT] && mask[`OBT_FLAG_CAPT])) begin
      pend.valid = 1'b1;
      pend.vector = `OBT_VEC_EMPTY;
    end
  end

  // gie held in processor_status_reg; hardware never saves it on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_status_reg <= 8'h00;
      isq <= OBT_IS_RUN;
      isq_cnt <= 3'h0;
      after_reti <= 1'b0;
      irq <= 1'b0;
      irq_vector <= 10'h000;
      irq_ack <= 1'b0;
    end else begin
      irq <= pend.valid;
      irq_ack <= 1'b0;
      if (cpu_wr) begin
        processor_status_reg <= pwdata[7:0];
      end
      unique case (isq)
        OBT_IS_RUN: begin
          if (after_reti) begin
            after_reti <= 1'b0;
          end else if (pend.valid && processor_status_reg[`OBT_CPU_GIE] &&
                       !processor_status_reg[`OBT_CPU_MULTI]) begin
            // vector is latched here so a later flag cannot change it mid-entry
            isq <= OBT_IS_ENTRY;
            isq_cnt <= `OBT_ENTRY_CYC - 3'h1;
            irq_vector <= pend.vector;
          end
        end
        OBT_IS_ENTRY: begin
          if (isq_cnt == 3'h0) begin
            isq <= OBT_IS_JUMP;
            isq_cnt <= `OBT_JUMP_CYC - 3'h1;
            irq_ack <= 1'b1;
          end else begin
            isq_cnt <= isq_cnt - 3'h1;
          end
        end
        OBT_IS_JUMP: begin
          if (isq_cnt == 3'h0) begin
            isq <= OBT_IS_HANDLER;
          end else begin
            isq_cnt <= isq_cnt - 3'h1;
          end
        end
        OBT_IS_HANDLER: begin
          if (cpu_wr && pwdata[`OBT_CPU_RETI]) begin
            isq <= OBT_IS_RETURN;
            isq_cnt <= `OBT_RETI_CYC - 3'h1;
          end
        end
        OBT_IS_RETURN: begin
          if (isq_cnt == 3'h0) begin
            isq <= OBT_IS_RUN;
            // the free cycle lets one main instruction run before the next entry
            after_reti <= 1'b1;
          end else begin
            isq_cnt <= isq_cnt - 3'h1;
          end
        end
      endcase
    end
  end

endmodule

// ---- obt_bit_timer_asserts.sv ----
`timescale 1ns/1ps
module obt_bit_timer_asserts #(
  parameter int CNT_W = 10
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic carrier_in, // carrier
  input wire logic capture_input_pin, // rx pin
  input wire logic key_out, // key
  input wire logic rf_out, // gated carrier
  input wire logic irq, // interrupt
  input wire logic [9:0] irq_vector, // vector
  input wire logic irq_ack // fetch strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err;
    pslverr |-> pready && prdata == 32'h0 && (paddr > 12'h014 || paddr[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("error on mapped address");
  property p_rf; rf_out |-> $past(carrier_in); endproperty
  a_rf: assert property (p_rf) else $error("rf without carrier");
  property p_rfkey; rf_out |-> key_out || $past(key_out); endproperty
  a_rfkey: assert property (p_rfkey) else $error("rf while unkeyed");
  property p_ack; irq_ack |=> !irq_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_entry; irq_ack |-> $past(irq, 3); endproperty
  a_entry: assert property (p_entry) else $error("entry too short");
  property p_vec; irq_ack |-> irq_vector == 10'h004 || irq_vector == 10'h002; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
endmodule

bind obt_bit_timer obt_bit_timer_asserts #(.CNT_W(CNT_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carrier_in(carrier_in), .capture_input_pin(capture_input_pin), .key_out(key_out),
  .rf_out(rf_out), .irq(irq), .irq_vector(irq_vector), .irq_ack(irq_ack)
);

// ---- obt_far_model.sv ----
`timescale 1ns/1ps
module obt_far_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic rx_level, // wanted receiver level
  output logic carrier_in, // carrier stand-in
  output logic capture_input_pin // receiver output
);
  // carrier toggles every cycle so gating is visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_in <= 1'b0;
      capture_input_pin <= 1'b0;
    end else begin
      carrier_in <= ~carrier_in;
      capture_input_pin <= rx_level;
    end
  end
endmodule

// ---- ook_bit_timer_test.sv ----
`timescale 1ns/1ps
`include "obt_defines.svh"
module ook_bit_timer_test import obt_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_level = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic er, pready, pslverr, carrier_in, capture_input_pin, key_out, rf_out, irq, irq_ack;
  logic [9:0] irq_vector;
  int fail_count = 0, n_compared = 0, cyc = 0, ack_cnt = 0, n, i, k;
  obt_bit_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .carrier_in(carrier_in), .capture_input_pin(capture_input_pin),
    .key_out(key_out), .rf_out(rf_out), .irq(irq), .irq_vector(irq_vector), .irq_ack(irq_ack));
  obt_far_model far (.pclk(pclk), .presetn(presetn), .rx_level(rx_level),
    .carrier_in(carrier_in), .capture_input_pin(capture_input_pin));
  always #10 pclk = ~pclk;
  // ==========
  // bus and checks
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task w8(input int s);
    for (k = 0; k < 2000; k++) begin
      @(posedge pclk);
      if (s == 0 && irq === 1'b1 || s == 1 && irq_ack === 1'b1 || s == 2 && key_out === 1'b1) break;
    end
    chk("wait event", 32'h1, {31'h0, k < 2000});
  endtask
  task test_done;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bound on a hang
  always @(posedge pclk) begin
    cyc++;
    if (irq_ack === 1'b1) ack_cnt++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  // ==========
  // tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      apb(12'(i * 4), 1'b0, 32'h0);
      chk("reset", 32'h0, rd);
    end
    apb(12'h020, 1'b0, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(`OBT_MASK_OFF, 1'b1, 32'h7);
    apb(`OBT_MASK_OFF, 1'b0, 32'h0);
    chk("mask", 32'h7, rd);
    apb(`OBT_MASK_OFF, 1'b1, 32'h0);
    $display("reg test done");
    for (i = 0; i < 2; i++) begin
      apb(`OBT_CLKDIV_OFF, 1'b1, 32'(i));
      apb(`OBT_CNT_OFF, 1'b1, i ? 32'h2 : 32'h3);
      apb(`OBT_CTRL_OFF, 1'b1, i ? 32'h43 : 32'h3);
      w8(2);
      for (n = 0; key_out === 1'b1 && n < 2000; n++) @(posedge pclk);
      chk("slot", i ? 32'h206 : 32'h4, n);
      apb(`OBT_STAT_OFF, 1'b0, 32'h0);
      chk("stat", 32'h5, rd);
      apb(`OBT_STAT_OFF, 1'b1, 32'h7);
      apb(`OBT_STAT_OFF, 1'b0, 32'h0);
      chk("clear", 32'h0, rd);
    end
    $display("tx test done");
    apb(`OBT_MASK_OFF, 1'b1, 32'h1);
    apb(`OBT_CTRL_OFF, 1'b1, 32'h3);
    w8(0);
    repeat (20) @(posedge pclk);
    chk("no gie", 32'h0, ack_cnt);
    apb(`OBT_CPU_OFF, 1'b1, 32'h3);
    repeat (20) @(posedge pclk);
    chk("busy", 32'h0, ack_cnt);
    apb(`OBT_CPU_OFF, 1'b1, 32'h1);
    w8(1);
    chk("entry cycles", 32'h1, {31'h0, k >= 4});
    @(posedge pclk);
    chk("ack", 32'h1, ack_cnt);
    chk("vector", 32'h4, {22'h0, irq_vector});
    apb(`OBT_STAT_OFF, 1'b1, 32'h7);
    apb(`OBT_CPU_OFF, 1'b1, 32'h5);
    apb(`OBT_CTRL_OFF, 1'b1, 32'h0);
    apb(`OBT_MASK_OFF, 1'b1, 32'h0);
    $display("irq test done");
    apb(`OBT_CLKDIV_OFF, 1'b1, 32'h0);
    apb(`OBT_CTRL_OFF, 1'b1, 32'h4);
    @(posedge pclk) rx_level <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(`OBT_CTRL_OFF, 1'b0, 32'h0);
    chk("rise", 32'h1, {31'h0, rd[0]});
    repeat (12) @(posedge pclk);
    rx_level <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(`OBT_CNT_OFF, 1'b0, 32'h0);
    chk("width", 32'h1, {31'h0, rd == 32'h13 || rd == 32'h14});
    apb(`OBT_CTRL_OFF, 1'b0, 32'h0);
    chk("fall", 32'h0, {31'h0, rd[0]});
    apb(`OBT_STAT_OFF, 1'b0, 32'h0);
    chk("edge", 32'h2, rd & 32'h2);
    $display("rx test done");
    apb(`OBT_STAT_OFF, 1'b1, 32'h7);
    apb(`OBT_CNT_OFF, 1'b1, 32'h4);
    apb(`OBT_CPU_OFF, 1'b1, 32'h0);
    apb(`OBT_MASK_OFF, 1'b1, 32'h4);
    apb(`OBT_CTRL_OFF, 1'b1, 32'h6);
    w8(0);
    // five ticks of interval, then the flag and irq register stages
    chk("gen time", 32'h6, k);
    n = 0;
    for (i = 0; i < 30; i++) begin
      @(posedge pclk);
      n += (key_out !== 1'b0);
    end
    chk("gen key", 32'h0, n);
    apb(`OBT_STAT_OFF, 1'b0, 32'h0);
    chk("gen flag", 32'h4, rd & 32'h4);
    $display("gen test done");
    test_done;
  end
endmodule
